// >>> hw/csp_defines.vh
// csp_defines.vh: addresses, reset values and bit positions of the status/power register bank
// assumes: included by the design files of the csp block
`ifndef CSP_DEFINES_VH
`define CSP_DEFINES_VH

`define CSP_ADDR_STATUS 8'hD0
`define CSP_ADDR_POWER 8'h87
`define CSP_RST_STATUS 8'h00
`define CSP_RST_POWER 8'h00
`define CSP_SFR_BASE_BIT 7
`define CSP_BITADDR_NIB_MASK 8'h07
`define CSP_BITADDR_NIB_ZERO 8'h00
`define CSP_BIT_SEL_MASK 8'hF8
`define CSP_UNMAPPED_READ 8'h00
`define CSP_BANK_BASE_SHIFT 3

`define CSP_ST_CARRY 7
`define CSP_ST_HALF 6
`define CSP_ST_UF0 5
`define CSP_ST_BANK_HI 4
`define CSP_ST_BANK_LO 3
`define CSP_ST_OVF 2
`define CSP_ST_UF1 1
`define CSP_ST_PARITY 0

`define CSP_PW_BAUD_DBL 7
`define CSP_PW_SER_WAKE 6
`define CSP_PW_IRQ0_WAKE 5
`define CSP_PW_LATCH_OFF 4
`define CSP_PW_SPARE_B 3
`define CSP_PW_SPARE_A 2
`define CSP_PW_PDOWN 1
`define CSP_PW_IDLE 0

`endif

// >>> hw/csp_sfr_reg.v
// csp_sfr_reg.v: one 8-bit special register with byte write, bit write and hardware update
// assumes: single sys_clk domain, write strobes one cycle wide, hardware mask from the core
`timescale 1ns/1ps
module csp_sfr_reg #(
    parameter WIDTH = 8,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
    input wire sys_clk,
    input wire rst_n,
    input wire byteWrite,
    input wire bitWrite,
    input wire [2:0] bitIndex,
    input wire bitValue,
    input wire [WIDTH-1:0] writeData,
    input wire [WIDTH-1:0] hwMask,
    input wire [WIDTH-1:0] hwData,
    output wire [WIDTH-1:0] value
);
    reg [WIDTH-1:0] value_reg;
    reg [WIDTH-1:0] value_next;
    integer i;

    // software write lands over the core's own flag updates in the same cycle
    always @* begin
        value_next = value_reg;
        for (i = 0; i < WIDTH; i = i + 1) begin
            if (hwMask[i]) begin
                value_next[i] = hwData[i];
            end
        end
        if (byteWrite) begin
            value_next = writeData;
        end else if (bitWrite) begin
            value_next[bitIndex] = bitValue;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            value_reg <= RESET_VALUE;
        end else begin
            value_reg <= value_next;
        end
    end

    assign value = value_reg;
endmodule

// >>> hw/csp_status_power_bank.v
// csp_status_power_bank.v: status word and power control registers of the core's special space
// assumes: core drives direct/indirect access strobes on sys_clk; other special registers
// live elsewhere and are muxed by the core using sfrHit
//
// Overview of operation
// - status word at D0H, reset 00H: flags, parity, two user flags, two-bit bank select.
// - power control at 87H, reset 00H, byte access only, spare flags free.
// - power control bit 7 doubles the serial port baud rate.
// - bit 5 lets external interrupt 0 wake, bit 6 lets serial interface wake.
// - all registers but program counter and register banks live in special space.
// - unoccupied special address has no register; its read value is undefined (this bank reads 00H there).
// - only addresses ending 0H or 8H allow single-bit access.
// - special space is upper 128 bytes, direct addressing only; indirect reaches RAM.
// - lowest 32 RAM bytes are four banks of eight registers, chosen by bank select.
`timescale 1ns/1ps
`include "csp_defines.vh"
module csp_status_power_bank (
    input wire sys_clk,
    input wire rst_n,
    input wire [7:0] sfrAddr,
    input wire directAccess,
    input wire readStrobe,
    input wire byteWriteStrobe,
    input wire bitWriteStrobe,
    input wire [2:0] bitIndex,
    input wire bitValue,
    input wire [7:0] writeData,
    input wire [7:0] statusHwMask,
    input wire [7:0] statusHwData,
    input wire [7:0] accValue,
    input wire [2:0] regOperand,
    output reg [7:0] readData,
    output wire sfrHit,
    output wire ramSelect,
    output wire bitAddressable,
    output wire [7:0] cpu_status_word,
    output wire [7:0] power_ctrl_reg,
    output wire carry_flag,
    output wire half_carry_flag,
    output wire arith_signed_error_flag,
    output wire [1:0] bankSelect,
    output wire [4:0] regRamAddr,
    output wire baud_doubler,
    output wire serial_wake_enable,
    output wire ext_irq0_wake_enable,
    output wire latch_strobe_disable,
    output wire power_down_enable,
    output wire cpu_halt_clock_mode
);
    wire upperHalf;
    wire statusSel;
    wire powerSel;
    wire [7:0] statusHwMaskFull;
    wire [7:0] statusHwDataFull;
    wire parityNow;
    wire [7:0] statusWriteData;
    wire statusBitValue;

    assign upperHalf = sfrAddr[`CSP_SFR_BASE_BIT];
    assign sfrHit = upperHalf & directAccess;
    assign ramSelect = ~sfrHit;
    assign bitAddressable = sfrHit & ((sfrAddr & `CSP_BITADDR_NIB_MASK) == `CSP_BITADDR_NIB_ZERO);
    assign statusSel = sfrHit & (sfrAddr == `CSP_ADDR_STATUS);
    assign powerSel = sfrHit & (sfrAddr == `CSP_ADDR_POWER);

    // parity follows the accumulator every cycle, so software cannot hold it
    assign parityNow = ^accValue;
    assign statusHwMaskFull = statusHwMask | (8'h01 << `CSP_ST_PARITY);
    assign statusHwDataFull = (statusHwData & ~(8'h01 << `CSP_ST_PARITY)) | ({7'h00, parityNow} << `CSP_ST_PARITY);
    // software writes would otherwise win over the parity bit for one cycle
    assign statusWriteData = (writeData & ~(8'h01 << `CSP_ST_PARITY)) | ({7'h00, parityNow} << `CSP_ST_PARITY);
    assign statusBitValue = (bitIndex == `CSP_ST_PARITY) ? parityNow : bitValue;

    // bit writes only reach the status word; power control ignores them
    // unoccupied addresses select neither register
    csp_sfr_reg #(
        .WIDTH(8),
        .RESET_VALUE(`CSP_RST_STATUS)
    ) statusReg (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .byteWrite(statusSel & byteWriteStrobe),
        .bitWrite(statusSel & bitWriteStrobe),
        .bitIndex(bitIndex),
        .bitValue(statusBitValue),
        .writeData(statusWriteData),
        .hwMask(statusHwMaskFull),
        .hwData(statusHwDataFull),
        .value(cpu_status_word)
    );

    csp_sfr_reg #(
        .WIDTH(8),
        .RESET_VALUE(`CSP_RST_POWER)
    ) powerReg (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .byteWrite(powerSel & byteWriteStrobe),
        .bitWrite(1'b0),
        .bitIndex(bitIndex),
        .bitValue(bitValue),
        .writeData(writeData),
        .hwMask(8'h00),
        .hwData(8'h00),
        .value(power_ctrl_reg)
    );

    // read data registered; unmapped locations give a fixed zero
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            readData <= `CSP_UNMAPPED_READ;
        end else if (readStrobe) begin
            if (statusSel) begin
                readData <= cpu_status_word;
            end else if (powerSel) begin
                readData <= power_ctrl_reg;
            end else begin
                readData <= `CSP_UNMAPPED_READ;
            end
        end
    end

    assign carry_flag = cpu_status_word[`CSP_ST_CARRY];
    assign half_carry_flag = cpu_status_word[`CSP_ST_HALF];
    assign arith_signed_error_flag = cpu_status_word[`CSP_ST_OVF];
    assign bankSelect = {cpu_status_word[`CSP_ST_BANK_HI], cpu_status_word[`CSP_ST_BANK_LO]};
    assign regRamAddr = {bankSelect, regOperand};

    assign baud_doubler = power_ctrl_reg[`CSP_PW_BAUD_DBL];
    assign serial_wake_enable = power_ctrl_reg[`CSP_PW_SER_WAKE];
    assign ext_irq0_wake_enable = power_ctrl_reg[`CSP_PW_IRQ0_WAKE];
    assign latch_strobe_disable = power_ctrl_reg[`CSP_PW_LATCH_OFF];
    assign power_down_enable = power_ctrl_reg[`CSP_PW_PDOWN];
    assign cpu_halt_clock_mode = power_ctrl_reg[`CSP_PW_IDLE];
endmodule

// >>> dv/csp_bank_asserts.sv
// checker for the status and power register bank
// assumes: bound to csp_status_power_bank, one clock domain
`timescale 1ns/1ps
module csp_bank_asserts (
input wire sys_clk, rst_n, directAccess, readStrobe, byteWriteStrobe, bitWriteStrobe,
input wire [7:0] sfrAddr, writeData, accValue, readData, cpu_status_word, power_ctrl_reg, statusHwMask,
input wire sfrHit, ramSelect, bitAddressable, baud_doubler, serial_wake_enable, ext_irq0_wake_enable,
input wire [2:0] regOperand,
input wire [1:0] bankSelect,
input wire [4:0] regRamAddr);
default clocking @(posedge sys_clk); endclocking
default disable iff (!rst_n);
wire pa = sfrHit && sfrAddr == 8'h87;
wire mapped = sfrHit && (sfrAddr == 8'hD0 || pa);
bank_addr_a: assert property (regRamAddr == {bankSelect, regOperand}) else $error("bank address");
sfr_decode_a: assert property (sfrHit == (sfrAddr[7] && directAccess) && ramSelect == !sfrHit) else $error("decode");
bit_access_a: assert property (bitAddressable == (sfrHit && sfrAddr[2:0] == 3'h0)) else $error("bit access");
power_write_a: assert property (byteWriteStrobe && pa |=> power_ctrl_reg == $past(writeData)) else $error("power wr");
power_bitwr_a: assert property (bitWriteStrobe && !byteWriteStrobe && pa |=> $stable(power_ctrl_reg)) else $error("bit wr");
power_bits_a: assert property ({baud_doubler, serial_wake_enable, ext_irq0_wake_enable} == power_ctrl_reg[7:5])
    else $error("power bits");
parity_bit_a: assert property (1'b1 |=> cpu_status_word[0] == ^$past(accValue)) else $error("parity");
stray_write_a: assert property (byteWriteStrobe && !mapped && statusHwMask == 8'h00
    |=> $stable(power_ctrl_reg) && $stable(cpu_status_word[7:1])) else $error("stray write");
read_back_a: assert property (readStrobe && pa |=> readData == $past(power_ctrl_reg)) else $error("read");
endmodule
bind csp_status_power_bank csp_bank_asserts i_chk (.*);

// >>> dv/csp_core_model.sv
// core side: issues direct or indirect special-register accesses
// assumes: shares sys_clk with the bank
`timescale 1ns/1ps
module csp_core_model (
input wire sys_clk,
output reg directAccess, readStrobe, byteWriteStrobe, bitWriteStrobe, bitValue,
output reg [7:0] sfrAddr, writeData, statusHwMask, statusHwData, accValue,
output reg [2:0] bitIndex, regOperand);
initial begin
{directAccess, readStrobe, byteWriteStrobe, bitWriteStrobe, bitValue} = 5'h00;
{sfrAddr, writeData, statusHwMask, statusHwData, accValue} = 40'h0;
{bitIndex, regOperand} = 6'h05;
end
// k: 0 read, 1 byte write, 2 bit write (d[2:0] index, d[3] value)
task acc(input [1:0] k, input [7:0] a, input [7:0] d, input dir);
begin
@(posedge sys_clk);
sfrAddr <= a;
directAccess <= dir;
writeData <= d;
{bitValue, bitIndex} <= d[3:0];
{readStrobe, byteWriteStrobe, bitWriteStrobe} <= {k == 2'h0, k == 2'h1, k == 2'h2};
@(posedge sys_clk);
{readStrobe, byteWriteStrobe, bitWriteStrobe} <= 3'h0;
#1;
end
endtask
endmodule

// >>> dv/tb_top.sv
// testbench: core model drives the bank, results compared here
// assumes: 20 MHz clock, no other bus
`timescale 1ns/1ps
module tb_top;
reg sys_clk = 0;
reg rst_n = 0;
integer bad_count = 0, n_tests = 0, b;
wire directAccess, readStrobe, byteWriteStrobe, bitWriteStrobe, bitValue, sfrHit, ramSelect, bitAddressable;
wire carry_flag, half_carry_flag, arith_signed_error_flag, baud_doubler, serial_wake_enable;
wire ext_irq0_wake_enable, latch_strobe_disable, power_down_enable, cpu_halt_clock_mode;
wire [7:0] sfrAddr, writeData, statusHwMask, statusHwData, accValue, readData, cpu_status_word, power_ctrl_reg;
wire [2:0] bitIndex, regOperand;
wire [1:0] bankSelect;
wire [4:0] regRamAddr;
csp_status_power_bank i_dut (.*);
csp_core_model i_core (.*);
task chk(input [7:0] got, input [7:0] exp);
begin
n_tests = n_tests + 1;
if (got !== exp) begin
bad_count = bad_count + 1;
$display("[ERR] %0t got %h want %h", $time, got, exp);
end
end
endtask
task finish_test;
begin
$display("compares %0d mismatches %0d", n_tests, bad_count);
if (bad_count == 0 && n_tests > 0)
$display("No errors found");
else
$display("Errors were found");
$finish;
end
endtask
initial forever #25 sys_clk = ~sys_clk;
initial begin
#100000;
bad_count = bad_count + 1;
finish_test;
end
initial begin
repeat (6) @(posedge sys_clk);
rst_n <= 1'b1;
#1 chk(cpu_status_word, 8'h00);
chk(power_ctrl_reg, 8'h00);
for (b = 0; b < 4; b = b + 1) begin
i_core.acc(2'h1, 8'hD0, b << 3, 1'b1);
chk(regRamAddr, (b << 3) | 5);
chk(cpu_status_word, b << 3);
end
i_core.acc(2'h1, 8'h87, 8'hFF, 1'b1);
chk(power_ctrl_reg, 8'hFF);
i_core.acc(2'h1, 8'h87, 8'hA0, 1'b1);
chk(baud_doubler << 2 | serial_wake_enable << 1 | ext_irq0_wake_enable, 8'h05);
i_core.acc(2'h2, 8'h87, 8'h07, 1'b1);
chk(power_ctrl_reg, 8'hA0);
i_core.acc(2'h2, 8'hD0, 8'h0D, 1'b1);
chk(cpu_status_word, 8'h38);
i_core.acc(2'h0, 8'h87, 8'h00, 1'b1);
chk(readData, 8'hA0);
i_core.acc(2'h1, 8'h87, 8'h11, 1'b0);
chk(power_ctrl_reg, 8'hA0);
i_core.acc(2'h1, 8'h88, 8'h11, 1'b1);
chk(power_ctrl_reg, 8'hA0);
i_core.acc(2'h0, 8'h9F, 8'h00, 1'b1);
chk(readData, 8'h00);
@(posedge sys_clk);
i_core.accValue <= 8'h07;
repeat (2) @(posedge sys_clk);
#1 chk(cpu_status_word, 8'h39);
i_core.acc(2'h1, 8'hD0, 8'h00, 1'b1);
chk(cpu_status_word, 8'h01);
@(posedge sys_clk);
i_core.statusHwMask <= 8'hC4;
i_core.statusHwData <= 8'hC4;
@(posedge sys_clk);
i_core.statusHwMask <= 8'h00;
#1 chk({carry_flag, half_carry_flag, arith_signed_error_flag}, 8'h07);
i_core.acc(2'h1, 8'h87, 8'h12, 1'b1);
chk({latch_strobe_disable, power_down_enable, cpu_halt_clock_mode}, 8'h06);
chk({sfrHit, ramSelect}, 8'h02);
finish_test;
end
endmodule
